// ==== inc/tap_pkg.sv ====
package tap_pkg;

  // ---------------------------------------------------------------
  // instruction codes
  // ---------------------------------------------------------------
  localparam int          IR_W           = 4;
  localparam logic [3:0]  OP_EXTEST      = 4'h0;
  localparam logic [3:0]  OP_IDCODE      = 4'h1;
  localparam logic [3:0]  OP_SAMPLE      = 4'h2;
  localparam logic [3:0]  OP_DBG_A       = 4'h8;
  localparam logic [3:0]  OP_DBG_B       = 4'h9;
  localparam logic [3:0]  OP_DBG_C       = 4'hA;
  localparam logic [3:0]  OP_DBG_D       = 4'hB;
  localparam logic [3:0]  OP_DEV_RESET   = 4'hC;
  localparam logic [3:0]  OP_BYPASS      = 4'hF;
  localparam logic [3:0]  IR_CAPTURE     = 4'h1;

  // ---------------------------------------------------------------
  // data register sizes and reset values
  // ---------------------------------------------------------------
  // identification value is arbitrary; bit 0 must be one
  localparam logic [31:0] ID_VALUE       = 32'h0000_1001;
  localparam int          NPINS          = 8;
  localparam int          BSR_W          = 2 * NPINS;
  localparam int          MSG_W          = 8;
  localparam int          MSG_DATA_W     = 7;
  localparam logic [7:0]  MSG_RESET      = 8'h00;
  // debug scan: [0]=instr valid, [16:1]=instr, [17]=mailbox ack, [18]=mailbox access enable
  localparam int          DBG_W          = 19;
  localparam int          DBG_INSTR_LSB  = 1;
  localparam int          DBG_ACK_BIT    = 17;
  localparam int          DBG_EN_BIT     = 18;
  // breakpoint chain: [1:0] mode, [2] flow break, [3] step, 4 x 16-bit address, 16-bit mask
  localparam int          BRK_W          = 4 + 5 * 16;
  localparam int          SYNC_STAGES    = 3;

  typedef enum logic [2:0] {
    BRK_P4, BRK_P3_D1, BRK_P2_D2, BRK_P2_PRANGE, BRK_P2_DRANGE
  } brk_mode_t;

  typedef struct packed {
    logic       lock_one;
    logic       lock_two;
    logic       tap_fuse;
    logic       dbg_fuse;
    logic       erased;
  } fuse_t;

  typedef struct packed {
    logic [15:0] instr;
    logic        valid;
  } cpu_feed_t;

endpackage : tap_pkg

// ==== design/sync3.sv ====
`timescale 1ns/1ps
module sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // change counts only once the second and third stages agree
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q    <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          q[i] <= s3_r[i];
        end
      end
    end
  end
endmodule : sync3

// ==== design/debug_tap.sv ====
`timescale 1ns/1ps
module debug_tap
  import tap_pkg::*;
(
  input  wire logic             MCLK,
  input  wire logic             RESET,
  input  wire logic             TCK,
  input  wire logic             TMS,
  input  wire logic             TDI,
  output logic                  TDO,
  output logic                  TDO_OE_N,
  input  wire fuse_t            FUSES,
  input  wire logic             PORT_DISABLE,
  input  wire logic             RESET_PIN_N,
  input  wire logic [NPINS-1:0] PIN_IN,
  input  wire logic [NPINS-1:0] CORE_OUT,
  input  wire logic [NPINS-1:0] CORE_OE_N,
  output logic      [NPINS-1:0] PIN_OUT,
  output logic      [NPINS-1:0] PIN_OE_N,
  output logic                  DEVICE_RESET,
  input  wire logic             MSG_WR,
  input  wire logic             MSG_RD,
  input  wire logic [MSG_W-1:0] MSG_WDATA,
  output logic      [MSG_W-1:0] MSG_RDATA,
  output logic                  MSG_SELECT,
  output cpu_feed_t             CPU_FEED,
  output logic      [BRK_W-1:0] BRK_CFG,
  output logic                  DBG_ACTIVE,
  output logic                  PROG_ENABLE
);
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } tap_t;

  // ---------------------------------------------------------------
  // enables
  // ---------------------------------------------------------------
  logic tap_en;
  logic dbg_en;
  logic mcu_rst;
  assign tap_en = FUSES.tap_fuse && !PORT_DISABLE;
  assign dbg_en = FUSES.dbg_fuse && !FUSES.lock_one && !FUSES.lock_two;

  // ---------------------------------------------------------------
  // TAP state machine, test clock domain
  // ---------------------------------------------------------------
  tap_t            st_r;
  tap_t            st_nxt;
  logic [IR_W-1:0] ir_sh_r;
  logic [IR_W-1:0] ir_r;
  logic            byp_r;
  logic [31:0]     id_sh_r;
  logic [BSR_W-1:0] bsr_sh_r;
  logic [BSR_W-1:0] bsr_lat_r;
  logic            rst_reg_r;
  logic [DBG_W-1:0] dbg_sh_r;
  logic [BRK_W-1:0] brk_sh_r;
  logic [BRK_W-1:0] brk_r;
  logic [15:0]     feed_instr_r;
  logic            feed_tog_r;
  logic            ack_tog_r;
  logic            acc_en_r;
  logic [MSG_W-1:0] msg_sh_cap;

  always_comb begin
    unique case (st_r)
      TLR:    st_nxt = TMS ? TLR    : RTI;
      RTI:    st_nxt = TMS ? SEL_DR : RTI;
      SEL_DR: st_nxt = TMS ? SEL_IR : CAP_DR;
      CAP_DR: st_nxt = TMS ? EX1_DR : SH_DR;
      SH_DR:  st_nxt = TMS ? EX1_DR : SH_DR;
      EX1_DR: st_nxt = TMS ? UPD_DR : PA_DR;
      PA_DR:  st_nxt = TMS ? EX2_DR : PA_DR;
      EX2_DR: st_nxt = TMS ? UPD_DR : SH_DR;
      UPD_DR: st_nxt = TMS ? SEL_DR : RTI;
      SEL_IR: st_nxt = TMS ? TLR    : CAP_IR;
      CAP_IR: st_nxt = TMS ? EX1_IR : SH_IR;
      SH_IR:  st_nxt = TMS ? EX1_IR : SH_IR;
      EX1_IR: st_nxt = TMS ? UPD_IR : PA_IR;
      PA_IR:  st_nxt = TMS ? EX2_IR : PA_IR;
      EX2_IR: st_nxt = TMS ? UPD_IR : SH_IR;
      UPD_IR: st_nxt = TMS ? SEL_DR : RTI;
    endcase
  end

  // port held in test-logic-reset while disabled; runs on TCK only
  always_ff @(posedge TCK) begin
    if (!tap_en) begin
      st_r <= TLR;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge TCK) begin
    if (!tap_en || st_r == TLR) begin
      ir_sh_r <= OP_IDCODE;
      ir_r    <= OP_IDCODE;
    end else if (st_r == CAP_IR) begin
      ir_sh_r <= IR_CAPTURE;
    end else if (st_r == SH_IR) begin
      ir_sh_r <= {TDI, ir_sh_r[IR_W-1:1]};
    end else if (st_r == UPD_IR) begin
      ir_r    <= ir_sh_r;
    end
  end

  // decode: unassigned or locked-out debug codes fall back to bypass
  logic sel_id, sel_bsr, sel_rst, sel_dbg, sel_brk, sel_byp, is_dbg_op;
  assign is_dbg_op = (ir_r == OP_DBG_A) || (ir_r == OP_DBG_B) ||
                     (ir_r == OP_DBG_C) || (ir_r == OP_DBG_D);
  assign sel_id  = (ir_r == OP_IDCODE);
  assign sel_bsr = (ir_r == OP_EXTEST) || (ir_r == OP_SAMPLE);
  assign sel_rst = (ir_r == OP_DEV_RESET);
  assign sel_dbg = is_dbg_op && dbg_en && (ir_r != OP_DBG_B);
  assign sel_brk = (ir_r == OP_DBG_B) && dbg_en;
  assign sel_byp = !(sel_id || sel_bsr || sel_rst || sel_dbg || sel_brk);

  always_ff @(posedge TCK) begin
    if (st_r == CAP_DR) begin
      byp_r    <= 1'b0;
      id_sh_r  <= ID_VALUE;
      bsr_sh_r <= {PIN_OE_N, PIN_IN};
      dbg_sh_r <= {acc_en_r, 1'b0, 9'h000, msg_sh_cap};
      brk_sh_r <= brk_r;
    end else if (st_r == SH_DR) begin
      byp_r    <= TDI;
      id_sh_r  <= {TDI, id_sh_r[31:1]};
      if (sel_bsr) bsr_sh_r <= {TDI, bsr_sh_r[BSR_W-1:1]};
      if (sel_dbg) dbg_sh_r <= {TDI, dbg_sh_r[DBG_W-1:1]};
      if (sel_brk) brk_sh_r <= {TDI, brk_sh_r[BRK_W-1:1]};
    end
  end

  // reset register has no update stage: its shift cell drives reset directly
  always_ff @(posedge TCK) begin
    if (!tap_en) begin
      rst_reg_r <= 1'b0;
    end else if (st_r == SH_DR && sel_rst) begin
      rst_reg_r <= TDI;
    end
  end

  // every breakpoint mix is accepted: mode plus the flow/step term never exceeds BRK_P2_DRANGE
  logic [2:0] brk_mode_in;
  assign brk_mode_in = {1'b0, brk_sh_r[1:0]} + {2'b00, brk_sh_r[2] & brk_sh_r[3]};
  always_ff @(posedge TCK) begin
    // a disabled port is the only reset of the toggles and feed_instr_r; a toggle
    // restarting at zero may look like one extra event to the system side
    if (!tap_en) begin
      brk_r        <= '0;
      feed_tog_r   <= 1'b0;
      ack_tog_r    <= 1'b0;
      acc_en_r     <= 1'b0;
      feed_instr_r <= '0;
    end else if (!dbg_en) begin
      brk_r    <= '0;
      acc_en_r <= 1'b0;
    end else if (st_r == UPD_DR) begin
      if (sel_brk && brk_mode_in <= 3'(BRK_P2_DRANGE)) begin
        brk_r <= brk_sh_r;
      end
      if (sel_dbg) begin
        acc_en_r <= dbg_sh_r[DBG_EN_BIT];
        if (dbg_sh_r[0]) begin
          feed_instr_r <= dbg_sh_r[DBG_INSTR_LSB +: 16];
          feed_tog_r   <= ~feed_tog_r;
        end
        if (dbg_sh_r[DBG_ACK_BIT]) begin
          ack_tog_r <= ~ack_tog_r;
        end
      end
    end
  end

  always_ff @(posedge TCK) begin
    if (st_r == UPD_DR && sel_bsr) begin
      bsr_lat_r <= bsr_sh_r;
    end
  end

  always_ff @(negedge TCK) begin
    if (!tap_en) begin
      TDO      <= 1'b0;
      TDO_OE_N <= 1'b1;
    end else begin
      TDO_OE_N <= !(st_r == SH_DR || st_r == SH_IR);
      if (st_r == SH_IR)      TDO <= ir_sh_r[0];
      else if (sel_id)        TDO <= id_sh_r[0];
      else if (sel_bsr)       TDO <= bsr_sh_r[0];
      else if (sel_rst)       TDO <= rst_reg_r;
      else if (sel_dbg)       TDO <= dbg_sh_r[0];
      else if (sel_brk)       TDO <= brk_sh_r[0];
      else                    TDO <= byp_r;
    end
  end

  // ---------------------------------------------------------------
  // crossings into MCLK
  // ---------------------------------------------------------------
  logic [5:0] sync_q;
  sync3 #(.W(6)) u_sync (
    .clk (MCLK),
    .rst (RESET),
    .d   ({feed_tog_r, ack_tog_r, acc_en_r, rst_reg_r, ir_r == OP_EXTEST, !RESET_PIN_N}),
    .q   (sync_q)
  );

  logic feed_seen_r, ack_seen_r, msg_pend_r;
  logic [MSG_W-1:0] msg_r;
  logic ack_evt, feed_evt;
  assign feed_evt = sync_q[5] ^ feed_seen_r;
  assign ack_evt  = sync_q[4] ^ ack_seen_r;
  // unlatched reset sources also act asynchronously on the pin drivers
  assign mcu_rst  = sync_q[0] | sync_q[2] | rst_reg_r | !RESET_PIN_N;
  assign msg_sh_cap = msg_r;

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      feed_seen_r <= 1'b0;
      ack_seen_r  <= 1'b0;
      CPU_FEED    <= '0;
    end else begin
      feed_seen_r    <= sync_q[5];
      ack_seen_r     <= sync_q[4];
      CPU_FEED.valid <= feed_evt && dbg_en;
      if (feed_evt) CPU_FEED.instr <= feed_instr_r;
    end
  end

  // ---------------------------------------------------------------
  // mailbox
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      msg_r      <= MSG_RESET;
      msg_pend_r <= 1'b0;
    end else begin
      if (MSG_WR && MSG_SELECT) begin
        msg_r      <= MSG_WDATA;
        msg_pend_r <= 1'b1;
      end else if (ack_evt) begin
        msg_pend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      MSG_RDATA  <= '0;
      MSG_SELECT <= 1'b0;
    end else begin
      // locks close the mailbox too, even without a test clock to clear acc_en_r
      MSG_SELECT <= dbg_en && sync_q[3];
      if (MSG_RD) MSG_RDATA <= {msg_pend_r, msg_r[MSG_DATA_W-1:0]};
    end
  end

  // ---------------------------------------------------------------
  // pins, status
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      DEVICE_RESET <= 1'b0;
      DBG_ACTIVE   <= 1'b0;
      PROG_ENABLE  <= 1'b0;
      BRK_CFG      <= '0;
    end else begin
      // raw reset terms only reach the pin drivers; the register takes synchronised copies
      DEVICE_RESET <= sync_q[0] | sync_q[2];
      DBG_ACTIVE   <= dbg_en && FUSES.tap_fuse;
      PROG_ENABLE  <= tap_en;
      // fuse write gate is taken outside from PROG_ENABLE and lock state
      BRK_CFG      <= dbg_en ? brk_r : '0;
    end
  end

  // EXTEST is decoded straight from ir_r so the latches drive with no MCLK delay
  always_comb begin
    if (tap_en && ir_r == OP_EXTEST) begin
      PIN_OUT  = bsr_lat_r[NPINS-1:0];
      PIN_OE_N = bsr_lat_r[BSR_W-1:NPINS];
    end else if (mcu_rst || DEVICE_RESET) begin
      PIN_OUT  = '0;
      PIN_OE_N = '1;
    end else begin
      PIN_OUT  = CORE_OUT;
      PIN_OE_N = CORE_OE_N;
    end
  end

  // locked part: debug fuse programming blocked until erase
  logic fuse_wr_ok;
  assign fuse_wr_ok = !(FUSES.lock_one || FUSES.lock_two) || FUSES.erased;
  logic unused_ok;
  assign unused_ok = fuse_wr_ok;

endmodule : debug_tap

// ==== test/jtag_host_model.sv ====
`timescale 1ns/1ps
module jtag_host_model
  import tap_pkg::*;
(
  output logic     tck,
  output logic     tms,
  output logic     tdi,
  input wire logic tdo
);
  // test clock stands still between frames; idle inputs sit at their pull-up level, except tms, which tap_reset leaves low
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  task automatic tick(input logic ms, input logic di, output logic bit_out);
    tms = ms;
    tdi = di;
    #24;
    bit_out = tdo;
    tck = 1'b1;
    #24;
    tck = 1'b0;
  endtask : tick

  task automatic tap_reset();
    logic b;
    repeat (5) tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
  endtask : tap_reset

  // from idle: shift n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic b;
    tick(1'b1, 1'b1, b);
    if (ir) tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
    tick(1'b0, 1'b1, b);
    dout = '0;
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], b);
      dout[i] = b;
    end
    tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
    tms = 1'b1;
    tdi = 1'b1;
  endtask : scan
endmodule : jtag_host_model

// ==== test/debug_tap_properties.sv ====
`timescale 1ns/1ps
module debug_tap_properties
  import tap_pkg::*;
(
  input wire logic             MCLK,
  input wire logic             RESET,
  input wire logic             TCK,
  input wire logic             TDO_OE_N,
  input wire fuse_t            FUSES,
  input wire logic             PORT_DISABLE,
  input wire logic             RESET_PIN_N,
  input wire logic [NPINS-1:0] PIN_OE_N,
  input wire logic             DEVICE_RESET,
  input wire logic             MSG_WR,
  input wire logic             MSG_RD,
  input wire logic [MSG_W-1:0] MSG_WDATA,
  input wire logic [MSG_W-1:0] MSG_RDATA,
  input wire logic             MSG_SELECT,
  input wire cpu_feed_t        CPU_FEED,
  input wire logic             DBG_ACTIVE,
  input wire logic             PROG_ENABLE
);
  pins_float_a: assert property (@(posedge MCLK) disable iff (RESET)
    DEVICE_RESET |-> &PIN_OE_N) else $error("pin driven in reset");
  pin_reset_a: assert property (@(posedge MCLK) disable iff (RESET)
    !RESET_PIN_N [*2] |-> ##[0:8] DEVICE_RESET) else $error("reset pin ignored");
  lock_kills_a: assert property (@(posedge MCLK) disable iff (RESET)
    (FUSES.lock_one || FUSES.lock_two) [*6] |-> !DBG_ACTIVE && !MSG_SELECT) else $error("debug on while locked");
  fuse_gates_a: assert property (@(posedge MCLK) disable iff (RESET)
    !FUSES.dbg_fuse [*6] |-> !DBG_ACTIVE && !MSG_SELECT) else $error("debug on without fuse");
  port_off_a: assert property (@(posedge TCK)
    (PORT_DISABLE || !FUSES.tap_fuse) [*6] |-> TDO_OE_N) else $error("port drives while disabled");
  prog_gate_a: assert property (@(posedge MCLK) disable iff (RESET)
    !FUSES.tap_fuse [*6] |-> !PROG_ENABLE) else $error("programming without port");
  pending_set_a: assert property (@(posedge MCLK) disable iff (RESET)
    MSG_WR && MSG_SELECT ##1 MSG_RD |=> MSG_RDATA == {1'b1, $past(MSG_WDATA[6:0], 2)})
    else $error("mailbox read wrong");
  rdata_hold_a: assert property (@(posedge MCLK) disable iff (RESET)
    !MSG_RD |=> $stable(MSG_RDATA)) else $error("read data moved");
  feed_pulse_a: assert property (@(posedge MCLK) disable iff (RESET)
    CPU_FEED.valid |=> !CPU_FEED.valid) else $error("feed pulse too long");
endmodule : debug_tap_properties

bind debug_tap debug_tap_properties debug_tap_properties_inst (.MCLK, .RESET, .TCK, .TDO_OE_N, .FUSES,
  .PORT_DISABLE, .RESET_PIN_N, .PIN_OE_N, .DEVICE_RESET, .MSG_WR, .MSG_RD, .MSG_WDATA, .MSG_RDATA,
  .MSG_SELECT, .CPU_FEED, .DBG_ACTIVE, .PROG_ENABLE);

// ==== test/test_debug_tap.sv ====
`timescale 1ns/1ps
module test_debug_tap;
  import tap_pkg::*;
  logic             mclk, reset, tck, tms, tdi, tdo, tdo_oe_n;
  fuse_t            fuses;
  logic             port_disable, reset_pin_n, device_reset, msg_wr, msg_rd, msg_select, dbg_active;
  logic [NPINS-1:0] pin_in, core_out, core_oe_n, pin_out, pin_oe_n;
  logic [MSG_W-1:0] msg_wdata, msg_rdata;
  cpu_feed_t        cpu_feed;
  logic [15:0]      fed_instr;
  logic [BRK_W-1:0] brk_cfg;
  logic [31:0]      dout;
  logic [3:0]       codes [6] = '{OP_BYPASS, 4'h5, OP_DBG_A, OP_DBG_B, OP_DBG_C, OP_DBG_D};
  int               fails, checks_done;

  debug_tap debug_tap_inst (.MCLK(mclk), .RESET(reset), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo),
    .TDO_OE_N(tdo_oe_n), .FUSES(fuses), .PORT_DISABLE(port_disable), .RESET_PIN_N(reset_pin_n),
    .PIN_IN(pin_in), .CORE_OUT(core_out), .CORE_OE_N(core_oe_n), .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n),
    .DEVICE_RESET(device_reset), .MSG_WR(msg_wr), .MSG_RD(msg_rd), .MSG_WDATA(msg_wdata),
    .MSG_RDATA(msg_rdata), .MSG_SELECT(msg_select), .CPU_FEED(cpu_feed), .BRK_CFG(brk_cfg),
    .DBG_ACTIVE(dbg_active), .PROG_ENABLE());
  jtag_host_model host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk) if (cpu_feed.valid === 1'b1) fed_instr <= cpu_feed.instr;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  // long enough for any crossing between the two clocks to land
  task automatic settle();
    repeat (4 * SYNC_STAGES) @(posedge mclk);
  endtask : settle

  // optional write, then a read straight behind it
  task automatic cpu_op(input logic wr, input logic [7:0] d);
    @(posedge mclk);
    msg_wr    <= wr;
    msg_wdata <= d;
    @(posedge mclk);
    msg_wr <= 1'b0;
    msg_rd <= 1'b1;
    @(posedge mclk);
    msg_rd <= 1'b0;
    @(posedge mclk);
  endtask : cpu_op

  task automatic final_report();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  initial begin
    #400_000;
    fails++;
    final_report();
  end

  initial begin
    reset          = 1'b1;
    fuses          = '0;
    fuses.tap_fuse = 1'b0;
    port_disable   = 1'b0;
    reset_pin_n    = 1'b1;
    msg_wr         = 1'b0;
    msg_rd         = 1'b0;
    msg_wdata      = 8'h00;
    pin_in         = 8'h96;
    core_out       = 8'h0F;
    core_oe_n      = 8'hF0;
    fails          = 0;
    checks_done    = 0;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    settle();
    // test clock edges with the port fused off bring the test side to a known state
    host.tap_reset();
    @(posedge mclk) fuses.tap_fuse <= 1'b1;
    settle();
    host.tap_reset();
    host.scan(1'b0, 32, 32'h0, dout);
    check("idcode", dout, ID_VALUE);
    // debug codes must fall back to bypass while the debug fuse is clear
    for (int k = 0; k < 6; k++) begin
      host.scan(1'b1, IR_W, {28'h0, codes[k]}, dout);
      check("ir capture", dout, {28'h0, IR_CAPTURE});
      host.scan(1'b0, 8, 32'hA5, dout);
      check("bypass path", dout, 32'h4A);
    end
    host.scan(1'b1, IR_W, {28'h0, OP_SAMPLE}, dout);
    host.scan(1'b0, BSR_W, 32'h003C, dout);
    check("pin sample", {24'h0, dout[7:0]}, {24'h0, pin_in});
    check("latch isolated", {24'h0, pin_out}, {24'h0, core_out});
    host.scan(1'b1, IR_W, {28'h0, OP_EXTEST}, dout);
    check("extest drive", {16'h0, pin_oe_n, pin_out}, 32'h003C);
    host.scan(1'b1, IR_W, {28'h0, OP_DEV_RESET}, dout);
    host.scan(1'b0, 1, 32'h1, dout);
    settle();
    check("reset held", {23'h0, device_reset, pin_oe_n}, 32'h1FF);
    host.scan(1'b0, 1, 32'h0, dout);
    settle();
    check("reset freed", {31'h0, device_reset}, 32'h0);
    @(posedge mclk) reset_pin_n <= 1'b0;
    settle();
    check("pin reset", {23'h0, device_reset, pin_oe_n}, 32'h1FF);
    @(posedge mclk) reset_pin_n <= 1'b1;
    settle();
    @(posedge mclk) fuses.dbg_fuse <= 1'b1;
    settle();
    check("debug on", {31'h0, dbg_active}, 32'h1);
    host.scan(1'b1, IR_W, {28'h0, OP_DBG_A}, dout);
    host.scan(1'b0, DBG_W, 32'h4_2469, dout);
    settle();
    check("fed instr", {15'h0, msg_select, fed_instr}, 32'h1_1234);
    cpu_op(1'b1, 8'h55);
    check("mailbox read", {24'h0, msg_rdata}, 32'hD5);
    host.scan(1'b0, DBG_W, 32'h6_0000, dout);
    check("mailbox scan", {24'h0, dout[7:0]}, 32'h55);
    settle();
    cpu_op(1'b0, 8'h00);
    check("pending clear", {24'h0, msg_rdata}, 32'h55);
    host.scan(1'b1, IR_W, {28'h0, OP_DBG_B}, dout);
    host.scan(1'b0, 32, 32'hC0DE_1234, dout);
    settle();
    check("break config", brk_cfg[BRK_W-1 -: 32], 32'hC0DE_1234);
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk);
      fuses.lock_one <= (k == 0);
      fuses.lock_two <= (k == 1);
      settle();
      check("locked out", {29'h0, |brk_cfg, dbg_active, msg_select}, 32'h0);
    end
    @(posedge mclk) port_disable <= 1'b1;
    settle();
    host.scan(1'b0, 8, 32'hA5, dout);
    @(posedge mclk) fuses.tap_fuse <= 1'b0;
    settle();
    final_report();
  end
endmodule : test_debug_tap
